// *** hdl/pin_ctrl_pkg.sv ***
// Shared constants, register map and carrier types for the port pin control block.
package pin_ctrl_pkg;

  // Widths of the bus and the ports.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam int PD_W = 3;

  // Register indices; every register is one byte wide.
  localparam logic [ADDR_W-1:0] ADR_DIN_B = 5'h00;
  localparam logic [ADDR_W-1:0] ADR_DIN_C = 5'h01;
  localparam logic [ADDR_W-1:0] ADR_DIN_D = 5'h02;
  localparam logic [ADDR_W-1:0] ADR_DOUT_B = 5'h04;
  localparam logic [ADDR_W-1:0] ADR_DOUT_C = 5'h05;
  localparam logic [ADDR_W-1:0] ADR_DOUT_D = 5'h06;
  localparam logic [ADDR_W-1:0] ADR_DIR_B = 5'h08;
  localparam logic [ADDR_W-1:0] ADR_DIR_C = 5'h09;
  localparam logic [ADDR_W-1:0] ADR_DIR_D = 5'h0A;
  localparam logic [ADDR_W-1:0] ADR_DRV_B = 5'h0C;
  localparam logic [ADDR_W-1:0] ADR_DRV_C = 5'h0D;
  localparam logic [ADDR_W-1:0] ADR_DRV_D = 5'h0E;
  localparam logic [ADDR_W-1:0] ADR_OEDEF_B = 5'h10;
  localparam logic [ADDR_W-1:0] ADR_OEDEF_C = 5'h11;
  localparam logic [ADDR_W-1:0] ADR_OEDEF_D = 5'h12;
  localparam logic [ADDR_W-1:0] ADR_PLDDRV_B = 5'h14;
  localparam logic [ADDR_W-1:0] ADR_PLDDRV_C = 5'h15;
  localparam logic [ADDR_W-1:0] ADR_PLDDRV_D = 5'h16;
  localparam logic [ADDR_W-1:0] ADR_CELL_SEL = 5'h18;
  localparam logic [ADDR_W-1:0] ADR_IMC_B = 5'h19;
  localparam logic [ADDR_W-1:0] ADR_IMC_C = 5'h1A;
  localparam logic [ADDR_W-1:0] ADR_MISC = 5'h1C;

  // Reset value of every register and the value of unmapped reads.
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // Writable bit masks per port; port D has three pins only.
  localparam logic [DATA_W-1:0] ALL_MASK = 8'hFF;
  localparam logic [DATA_W-1:0] PD_MASK = 8'h07;

  // Drive select capabilities per bit.
  localparam logic [DATA_W-1:0] B_OD_MASK = 8'hF0;
  localparam logic [DATA_W-1:0] B_SLEW_MASK = 8'h0F;
  localparam logic [DATA_W-1:0] C_OD_MASK = 8'hFF;
  localparam logic [DATA_W-1:0] C_SLEW_MASK = 8'h00;
  localparam logic [DATA_W-1:0] D_OD_MASK = 8'h00;
  localparam logic [DATA_W-1:0] D_SLEW_MASK = 8'h07;

  // Fields of the miscellaneous configuration register.
  localparam int MISC_JTAG_BIT = 0;
  localparam int MISC_PLD_CLOCK_INPUT_BIT = 1;
  localparam int MISC_CSI_BIT = 2;
  localparam int MISC_POL_LSB = 3;
  localparam logic [DATA_W-1:0] MISC_MASK = 8'h3F;

  // Port C pins taken by the programming port, and port D dedicated pins.
  localparam logic [DATA_W-1:0] JTAG_IN_MASK = 8'h07;
  localparam logic [DATA_W-1:0] JTAG_TDO_MASK = 8'h08;
  localparam int PD_CLK_PIN = 1;
  localparam int PD_CSI_PIN = 2;
  localparam logic [DATA_W-1:0] PD_CLK_MASK = 8'h02;
  localparam logic [DATA_W-1:0] PD_CSI_MASK = 8'h04;

  // Per-port configuration carried from the register file to the pin drivers.
  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] dout;
    logic [PORT_W-1:0] drv;
    logic [PORT_W-1:0] oe_def;
    logic [PORT_W-1:0] pld_drv;
  } port_cfg_t;

  // One register bus request from the signal processor.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

endpackage : pin_ctrl_pkg

// *** hdl/port_pin_direction_drive_control.sv ***
// Register file and pin control of general ports B, C and D.
//
// Notes on behaviour
// - Without an enable product term, direction bit 0 means input, 1 output.
// - With an enable product term, pin drives if direction bit or term is 1.
// - Port D direction register has only its three low bits active.
// - Open-drain capable pin is open drain when its drive bit is 1, else CMOS.
// - Slew-capable pin uses high slew when its drive bit is 1, else standard.
// - Port B drive bits 7..4 select open drain, bits 3..0 fast slew.
// - Port C drive bits all select open drain; port C has no slew control.
// - Port D drive bits 2..0 select fast slew; bits 7..3 do nothing.
// - Port-B-only cells go to port B; shared cells go to B or C.
// - Port B and C pin inputs reach the array through input macrocells.
// - Port C may carry the programming port, shared with other functions.
// - Port D inputs enter the array directly, without macrocells.
// - Port D pin one may serve as the output macrocell clock input.
// - Chip select input high on port D pin two puts flash in standby.
// - Three external selects, one product term each, polarity configurable.
// - External select pin driver enabled by its enable term or direction bit.
// - External selects use no output macrocell; B or C cells give more.
// - Data in read returns the real level on each pin.
// - Data out drives the pin unless the logic array or the programming port drives it.
// - Bit n of each port register belongs to pin n of that port.
// - All direction bits are 0 after reset, so all pins start as inputs.
`timescale 1ns/1ns
module port_pin_direction_drive_control (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire pin_ctrl_pkg::bus_req_t bus_req, // Register read or write request.
  output logic [7:0] bus_rdata, // Read data, valid the cycle after a read.
  input wire logic [7:0] port_b_in, // Port B pin levels.
  output logic [7:0] port_b_out, // Port B output levels.
  output logic [7:0] port_b_oe_n, // Port B output enables, low drives.
  output logic [7:0] port_b_slew_fast, // Port B high slew selects.
  input wire logic [7:0] port_c_in, // Port C pin levels.
  output logic [7:0] port_c_out, // Port C output levels.
  output logic [7:0] port_c_oe_n, // Port C output enables, low drives.
  input wire logic [2:0] port_d_in, // Port D pin levels.
  output logic [2:0] port_d_out, // Port D output levels.
  output logic [2:0] port_d_oe_n, // Port D output enables, low drives.
  output logic [2:0] port_d_slew_fast, // Port D high slew selects.
  input wire logic [7:0] portb_only_output_cells, // Cells that serve port B alone.
  input wire logic [7:0] shared_output_cells, // Cells that serve port B or C.
  input wire logic [7:0] oe_term_b, // Port B output enable product terms.
  input wire logic [7:0] oe_term_c, // Port C output enable product terms.
  input wire logic [2:0] oe_term_d, // Port D output enable product terms.
  input wire logic [2:0] external_select_terms, // One select product term per pin.
  input wire logic imc_capture_b, // Port B macrocell capture product term.
  input wire logic imc_capture_c, // Port C macrocell capture product term.
  output logic [7:0] input_macrocell_b, // Port B inputs to the array.
  output logic [7:0] input_macrocell_c, // Port C inputs to the array.
  output logic [2:0] port_d_array_in, // Port D direct inputs to the array.
  input wire logic jtag_tdo, // Test data out to port C.
  output logic [2:0] jtag_in, // Test mode, clock and data in from port C.
  output logic jtag_active, // Programming port owns its port C pins.
  output logic pld_clock_input, // Macrocell clock taken from port D pin one.
  output logic flash_standby // Flash deselected by the chip select input.
);
  import pin_ctrl_pkg::*;

  // Port registers.
  logic [7:0] dout_b_reg;
  logic [7:0] dout_c_reg;
  logic [7:0] dout_d_reg;
  logic [7:0] dir_b_reg;
  logic [7:0] dir_c_reg;
  logic [7:0] dir_d_reg;
  logic [7:0] port_b_drive_select_reg;
  logic [7:0] port_c_drive_select_reg;
  logic [7:0] port_d_drive_select_reg;
  logic [7:0] oedef_b_reg;
  logic [7:0] oedef_c_reg;
  logic [7:0] oedef_d_reg;
  logic [7:0] plddrv_b_reg;
  logic [7:0] plddrv_c_reg;
  logic [7:0] plddrv_d_reg;
  logic [7:0] cell_sel_reg;
  logic [7:0] imc_b_reg;
  logic [7:0] imc_c_reg;
  logic [7:0] misc_reg;
  logic [7:0] imc_b_data_reg;
  logic [7:0] imc_c_data_reg;
  logic [7:0] rdata_next;

  logic jtag_en;
  logic pld_clock_input_en;
  logic csi_en;
  logic [2:0] ecs_pol;
  logic selected;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] port_d_in_w;

  port_cfg_t cfg_b;
  port_cfg_t cfg_c;
  port_cfg_t cfg_d;
  logic [7:0] pld_b;
  logic [7:0] pld_c;
  logic [7:0] pld_d;
  logic [7:0] force_in_c;
  logic [7:0] force_out_c;
  logic [7:0] force_val_c;
  logic [7:0] force_in_d;
  logic [7:0] d_out_w;
  logic [7:0] d_oe_n_w;
  logic [7:0] d_slew_w;

  // Configuration fields.
  assign jtag_en = misc_reg[MISC_JTAG_BIT];
  assign pld_clock_input_en = misc_reg[MISC_PLD_CLOCK_INPUT_BIT];
  assign csi_en = misc_reg[MISC_CSI_BIT];
  assign ecs_pol = misc_reg[MISC_POL_LSB +: PD_W];
  assign port_d_in_w = {5'h00, port_d_in};

  // A high chip select input parks the flash and the register file, not the pins.
  assign flash_standby = csi_en && port_d_in[PD_CSI_PIN];
  assign selected = !flash_standby;
  assign wr_hit = bus_req.wr && selected;
  assign rd_hit = bus_req.rd && selected;

  // Data out registers; the port D copy keeps its three pins only.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_b_reg <= REG_RESET;
      dout_c_reg <= REG_RESET;
      dout_d_reg <= REG_RESET;
    end else if (wr_hit) begin
      case (bus_req.addr)
        ADR_DOUT_B: dout_b_reg <= bus_req.wdata;
        ADR_DOUT_C: dout_c_reg <= bus_req.wdata;
        ADR_DOUT_D: dout_d_reg <= bus_req.wdata & PD_MASK;
        default: ;
      endcase
    end
  end

  // Direction registers clear to all inputs at reset.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_b_reg <= REG_RESET;
      dir_c_reg <= REG_RESET;
      dir_d_reg <= REG_RESET;
    end else if (wr_hit) begin
      case (bus_req.addr)
        ADR_DIR_B: dir_b_reg <= bus_req.wdata;
        ADR_DIR_C: dir_c_reg <= bus_req.wdata;
        ADR_DIR_D: dir_d_reg <= bus_req.wdata & PD_MASK;
        default: ;
      endcase
    end
  end

  // Drive select registers store capable bits only, so the rest read zero.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_b_drive_select_reg <= REG_RESET;
      port_c_drive_select_reg <= REG_RESET;
      port_d_drive_select_reg <= REG_RESET;
    end else if (wr_hit) begin
      case (bus_req.addr)
        ADR_DRV_B: port_b_drive_select_reg <= bus_req.wdata & (B_OD_MASK | B_SLEW_MASK);
        ADR_DRV_C: port_c_drive_select_reg <= bus_req.wdata & C_OD_MASK;
        ADR_DRV_D: port_d_drive_select_reg <= bus_req.wdata & D_SLEW_MASK;
        default: ;
      endcase
    end
  end

  // Enable term definitions and array ownership of each pin.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oedef_b_reg <= REG_RESET;
      oedef_c_reg <= REG_RESET;
      oedef_d_reg <= REG_RESET;
      plddrv_b_reg <= REG_RESET;
      plddrv_c_reg <= REG_RESET;
      plddrv_d_reg <= REG_RESET;
    end else if (wr_hit) begin
      case (bus_req.addr)
        ADR_OEDEF_B: oedef_b_reg <= bus_req.wdata;
        ADR_OEDEF_C: oedef_c_reg <= bus_req.wdata;
        ADR_OEDEF_D: oedef_d_reg <= bus_req.wdata & PD_MASK;
        ADR_PLDDRV_B: plddrv_b_reg <= bus_req.wdata;
        ADR_PLDDRV_C: plddrv_c_reg <= bus_req.wdata;
        ADR_PLDDRV_D: plddrv_d_reg <= bus_req.wdata & PD_MASK;
        default: ;
      endcase
    end
  end

  // Cell routing, macrocell modes and dedicated pin functions.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_sel_reg <= REG_RESET;
      imc_b_reg <= REG_RESET;
      imc_c_reg <= REG_RESET;
      misc_reg <= REG_RESET;
    end else if (wr_hit) begin
      case (bus_req.addr)
        ADR_CELL_SEL: cell_sel_reg <= bus_req.wdata;
        ADR_IMC_B: imc_b_reg <= bus_req.wdata;
        ADR_IMC_C: imc_c_reg <= bus_req.wdata;
        ADR_MISC: misc_reg <= bus_req.wdata & MISC_MASK;
        default: ;
      endcase
    end
  end

  // Read multiplexer; data in shows the live pin level whoever drives it.
  always_comb begin
    rdata_next = REG_RESET;
    case (bus_req.addr)
      ADR_DIN_B: rdata_next = port_b_in;
      ADR_DIN_C: rdata_next = port_c_in;
      ADR_DIN_D: rdata_next = port_d_in_w;
      ADR_DOUT_B: rdata_next = dout_b_reg;
      ADR_DOUT_C: rdata_next = dout_c_reg;
      ADR_DOUT_D: rdata_next = dout_d_reg;
      ADR_DIR_B: rdata_next = dir_b_reg;
      ADR_DIR_C: rdata_next = dir_c_reg;
      ADR_DIR_D: rdata_next = dir_d_reg;
      ADR_DRV_B: rdata_next = port_b_drive_select_reg;
      ADR_DRV_C: rdata_next = port_c_drive_select_reg;
      ADR_DRV_D: rdata_next = port_d_drive_select_reg;
      ADR_OEDEF_B: rdata_next = oedef_b_reg;
      ADR_OEDEF_C: rdata_next = oedef_c_reg;
      ADR_OEDEF_D: rdata_next = oedef_d_reg;
      ADR_PLDDRV_B: rdata_next = plddrv_b_reg;
      ADR_PLDDRV_C: rdata_next = plddrv_c_reg;
      ADR_PLDDRV_D: rdata_next = plddrv_d_reg;
      ADR_CELL_SEL: rdata_next = cell_sel_reg;
      ADR_IMC_B: rdata_next = imc_b_reg;
      ADR_IMC_C: rdata_next = imc_c_reg;
      ADR_MISC: rdata_next = misc_reg;
      default: rdata_next = REG_RESET;
    endcase
  end

  // Read data is held until the next accepted read.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= REG_RESET;
    end else if (rd_hit) begin
      bus_rdata <= rdata_next;
    end
  end

  // Input macrocells: a mode bit of 1 captures on the capture term, 0 follows the pin.
  // A one-cycle sampling delay in follow mode keeps the array input glitch free.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      imc_b_data_reg <= REG_RESET;
      imc_c_data_reg <= REG_RESET;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (!imc_b_reg[i] || imc_capture_b) begin
          imc_b_data_reg[i] <= port_b_in[i];
        end
        if (!imc_c_reg[i] || imc_capture_c) begin
          imc_c_data_reg[i] <= port_c_in[i];
        end
      end
    end
  end

  assign input_macrocell_b = imc_b_data_reg;
  assign input_macrocell_c = imc_c_data_reg;

  // Port D bypasses the macrocells; pin one may clock the output cells.
  assign port_d_array_in = port_d_in;
  assign pld_clock_input = pld_clock_input_en && port_d_in[PD_CLK_PIN];

  // Programming port pins on port C; the other port C pins keep working.
  assign jtag_active = jtag_en;
  assign jtag_in = jtag_en ? port_c_in[2:0] : 3'h0;
  assign force_in_c = jtag_en ? JTAG_IN_MASK : 8'h00;
  assign force_out_c = jtag_en ? JTAG_TDO_MASK : 8'h00;
  assign force_val_c = jtag_tdo ? JTAG_TDO_MASK : 8'h00;

  // Dedicated port D inputs must never be driven by this end.
  assign force_in_d = (pld_clock_input_en ? PD_CLK_MASK : 8'h00) | (csi_en ? PD_CSI_MASK : 8'h00);

  // A shared cell goes to port B where selected, otherwise it is free for port C.
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pld_b[i] = cell_sel_reg[i] ? shared_output_cells[i] : portb_only_output_cells[i];
      pld_c[i] = shared_output_cells[i] && !cell_sel_reg[i];
    end
  end

  // External selects: one product term each, optionally inverted, no macrocell used.
  assign pld_d = {5'h00, external_select_terms ^ ecs_pol};

  assign cfg_b = '{dir: dir_b_reg, dout: dout_b_reg, drv: port_b_drive_select_reg,
                   oe_def: oedef_b_reg, pld_drv: plddrv_b_reg};
  assign cfg_c = '{dir: dir_c_reg, dout: dout_c_reg, drv: port_c_drive_select_reg,
                   oe_def: oedef_c_reg, pld_drv: plddrv_c_reg};
  assign cfg_d = '{dir: dir_d_reg, dout: dout_d_reg, drv: port_d_drive_select_reg,
                   oe_def: oedef_d_reg, pld_drv: plddrv_d_reg};

  // Port B driver: open drain on the upper half, slew on the lower half.
  port_pin_driver #(
    .OD_MASK(B_OD_MASK),
    .SLEW_MASK(B_SLEW_MASK)
  ) u_drv_b (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cfg(cfg_b),
    .pld_data(pld_b),
    .oe_term(oe_term_b),
    .force_in(8'h00),
    .force_out(8'h00),
    .force_val(8'h00),
    .pin_out(port_b_out),
    .pin_oe_n(port_b_oe_n),
    .slew_fast(port_b_slew_fast)
  );

  // Port C driver: open drain on every pin, no slew control.
  port_pin_driver #(
    .OD_MASK(C_OD_MASK),
    .SLEW_MASK(C_SLEW_MASK)
  ) u_drv_c (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cfg(cfg_c),
    .pld_data(pld_c),
    .oe_term(oe_term_c),
    .force_in(force_in_c),
    .force_out(force_out_c),
    .force_val(force_val_c),
    .pin_out(port_c_out),
    .pin_oe_n(port_c_oe_n),
    .slew_fast()
  );

  // Port D driver: select pins enabled by their term or direction bit.
  port_pin_driver #(
    .OD_MASK(D_OD_MASK),
    .SLEW_MASK(D_SLEW_MASK)
  ) u_drv_d (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cfg(cfg_d),
    .pld_data(pld_d),
    .oe_term({5'h00, oe_term_d}),
    .force_in(force_in_d),
    .force_out(8'h00),
    .force_val(8'h00),
    .pin_out(d_out_w),
    .pin_oe_n(d_oe_n_w),
    .slew_fast(d_slew_w)
  );

  // Only the three real port D pins leave the block.
  assign port_d_out = d_out_w[PD_W-1:0];
  assign port_d_oe_n = d_oe_n_w[PD_W-1:0];
  assign port_d_slew_fast = d_slew_w[PD_W-1:0];

endmodule : port_pin_direction_drive_control

// *** hdl/port_pin_driver.sv ***
// Output driver of one eight-pin port: source select, direction, open drain and slew.
`timescale 1ns/1ns
module port_pin_driver #(
  parameter logic [7:0] OD_MASK = 8'h00,
  parameter logic [7:0] SLEW_MASK = 8'h00
) (
  input wire logic sys_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire pin_ctrl_pkg::port_cfg_t cfg, // Register settings of this port.
  input wire logic [7:0] pld_data, // Logic array output per pin.
  input wire logic [7:0] oe_term, // Output enable product term per pin.
  input wire logic [7:0] force_in, // Pins held as inputs by a dedicated function.
  input wire logic [7:0] force_out, // Pins driven by a dedicated function.
  input wire logic [7:0] force_val, // Level for the dedicated outputs.
  output logic [7:0] pin_out, // Pin output level.
  output logic [7:0] pin_oe_n, // Pin output enable, low while driving.
  output logic [7:0] slew_fast // High slew rate select per pin.
);
  import pin_ctrl_pkg::*;

  // Only slew-capable bits pass the drive select through.
  assign slew_fast = cfg.drv & SLEW_MASK;

  genvar i;
  for (i = 0; i < 8; i++) begin : g_pin
    logic val;
    logic en;
    logic od;
    // The logic array overrides the data out bit wherever it drives the pin.
    assign val = force_out[i] ? force_val[i] : (cfg.pld_drv[i] ? pld_data[i] : cfg.dout[i]);
    // Direction bit alone, or ORed with the product term where one is defined.
    assign en = !force_in[i] &&
                (force_out[i] || cfg.dir[i] || (cfg.oe_def[i] && oe_term[i]));
    assign od = OD_MASK[i] & cfg.drv[i];

    // Open drain only ever pulls low; a high releases the pin to the pull-up.
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        pin_out[i] <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        pin_out[i] <= od ? 1'b0 : val;
        pin_oe_n[i] <= !(en && !(od && val));
      end
    end
  end

endmodule : port_pin_driver

// *** test/pin_ctrl_sva.sv ***
// Checker on the ports of the port pin control block.
`timescale 1ns/1ns
module pin_ctrl_sva (
  input wire logic sys_clk, // System clock.
  input wire logic reset_n, // Reset, active low.
  input wire pin_ctrl_pkg::bus_req_t bus_req, // Register request.
  input wire logic [7:0] bus_rdata, // Read data.
  input wire logic [7:0] port_b_oe_n, // Port B enables.
  input wire logic [7:0] port_c_in, // Port C levels.
  input wire logic [7:0] port_c_oe_n, // Port C enables.
  input wire logic [2:0] port_d_in, // Port D levels.
  input wire logic [2:0] port_d_oe_n, // Port D enables.
  input wire logic [2:0] port_d_array_in, // Port D array inputs.
  input wire logic [2:0] jtag_in, // Programming port inputs.
  input wire logic jtag_active, // Programming port on.
  input wire logic pld_clock_input, // Macrocell clock.
  input wire logic flash_standby // Flash deselected.
);
  import pin_ctrl_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // A read only counts while the chip select input leaves the registers reachable.
  logic rd_ok;
  assign rd_ok = bus_req.rd && !flash_standby;
  a_reset_inputs: assert property ($rose(reset_n) |-> &{port_b_oe_n, port_c_oe_n, port_d_oe_n})
    else $error("pins not all inputs after reset");
  a_standby_hold: assert property (flash_standby && bus_req.rd |=> $stable(bus_rdata))
    else $error("read accepted while deselected");
  a_dir_d_zero: assert property (rd_ok && bus_req.addr == ADR_DIR_D |=> bus_rdata[7:3] == 5'h00)
    else $error("unused port D direction bits read nonzero");
  a_drv_d_zero: assert property (rd_ok && bus_req.addr == ADR_DRV_D |=> bus_rdata[7:3] == 5'h00)
    else $error("unused port D drive bits read nonzero");
  a_direct_path: assert property (port_d_array_in == port_d_in)
    else $error("port D array input differs from pins");
  a_jtag_gate: assert property (jtag_in == (jtag_active ? port_c_in[2:0] : 3'h0))
    else $error("programming inputs wrong");
  a_jtag_inputs: assert property (jtag_active && $past(jtag_active) |-> &port_c_oe_n[2:0])
    else $error("programming input pins driven");
  a_clk_pin_one: assert property (pld_clock_input |-> port_d_in[1])
    else $error("macrocell clock high with pin low");
  a_standby_cause: assert property (flash_standby |-> port_d_in[2])
    else $error("standby without select input high");
  c_standby_read: cover property (flash_standby && bus_req.rd);
  c_jtag_on: cover property (jtag_active && pld_clock_input);
  c_dir_d_read: cover property (rd_ok && bus_req.addr == ADR_DIR_D);
endmodule : pin_ctrl_sva

// *** test/pin_world.sv ***
// Pin world model: pull-ups and switchable external drivers on ports B, C and D.
`timescale 1ns/1ns
module pin_world (
  input wire logic [18:0] dev_out, // Block output levels, port D in the top bits.
  input wire logic [18:0] dev_oe_n, // Block output enables, low drives.
  input wire logic [18:0] ext_en, // External drivers switched on.
  input wire logic [18:0] ext_val, // External driver levels.
  output logic [18:0] pin_lvl // Resolved pin levels fed back to the block.
);
  // A released pin rises to its pull-up, which open drain needs to show a one.
  always_comb begin
    for (int i = 0; i < 19; i++) begin
      pin_lvl[i] = !dev_oe_n[i] ? dev_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : pin_world

// *** test/tb.sv ***
// Top testbench: register tasks, pin world and checks of the port control block.
`timescale 1ns/1ns
bind port_pin_direction_drive_control pin_ctrl_sva pin_ctrl_sva_i (.sys_clk, .reset_n, .bus_req,
  .bus_rdata, .port_b_oe_n, .port_c_in, .port_c_oe_n, .port_d_in, .port_d_oe_n,
  .port_d_array_in, .jtag_in, .jtag_active, .pld_clock_input, .flash_standby);
module tb;
  import pin_ctrl_pkg::*;
  logic sys_clk, reset_n, imc_capture_b, imc_capture_c, jtag_tdo, jtag_active;
  logic pld_clock_input, flash_standby;
  bus_req_t bus_req;
  logic [7:0] bus_rdata, port_b_in, port_b_out, port_b_oe_n, port_b_slew_fast, port_c_in;
  logic [7:0] port_c_out, port_c_oe_n, portb_only_output_cells, shared_output_cells;
  logic [7:0] oe_term_b, oe_term_c, input_macrocell_b, input_macrocell_c;
  logic [2:0] port_d_in, port_d_out, port_d_oe_n, port_d_slew_fast, oe_term_d;
  logic [2:0] external_select_terms, port_d_array_in, jtag_in;
  logic [18:0] ext_en, ext_val, pin_lvl;
  int checks, failures;
  port_pin_direction_drive_control port_pin_direction_drive_control_i (.*);
  pin_world pin_world_i (.dev_out({port_d_out, port_c_out, port_b_out}),
    .dev_oe_n({port_d_oe_n, port_c_oe_n, port_b_oe_n}), .ext_en, .ext_val, .pin_lvl);
  assign {port_d_in, port_c_in, port_b_in} = pin_lvl;
  // Free running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    checks++;
    if (a !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk
  // Requests last one cycle and are launched on the falling edge.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    bus_req = '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    bus_req = '0;
    chk(bus_rdata, e);
  endtask : rd
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : w
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // The whole sequence takes about a hundred cycles; the watchdog allows far more.
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  // Test sequence.
  initial begin
    bus_req = '0;
    reset_n = 1'b0;
    ext_en = '0;
    ext_val = '0;
    {imc_capture_b, imc_capture_c, jtag_tdo} = 3'h0;
    {oe_term_b, oe_term_c, oe_term_d, external_select_terms} = '0;
    portb_only_output_cells = 8'hCC;
    shared_output_cells = 8'h33;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'b1;
    rd(ADR_DIR_B, 8'h00);
    chk(port_b_oe_n, 8'hFF);
    $display("test reset done");
    wr(ADR_DOUT_B, 8'h05);
    wr(ADR_DIR_B, 8'h07);
    w(2);
    chk(port_b_oe_n, 8'hF8);
    chk(port_b_out, 8'h05);
    rd(ADR_DIN_B, 8'hFD);
    $display("test direction done");
    wr(ADR_DIR_D, 8'hFF);
    rd(ADR_DIR_D, 8'h07);
    wr(ADR_DRV_D, 8'hFF);
    rd(ADR_DRV_D, 8'h07);
    chk({5'h00, port_d_slew_fast}, 8'h07);
    wr(ADR_DRV_B, 8'hFF);
    rd(ADR_DRV_B, 8'hFF);
    chk(port_b_slew_fast, 8'h0F);
    wr(ADR_DRV_B, 8'h00);
    chk(port_b_slew_fast, 8'h00);
    rd(5'h03, 8'h00);
    $display("test drive masks done");
    wr(ADR_OEDEF_C, 8'hFF);
    oe_term_c = 8'h0F;
    w(2);
    chk(port_c_oe_n, 8'hF0);
    oe_term_c = 8'h00;
    w(2);
    chk(port_c_oe_n, 8'hFF);
    wr(ADR_DOUT_C, 8'hAA);
    wr(ADR_DIR_C, 8'hFF);
    wr(ADR_DRV_C, 8'hFF);
    w(2);
    chk(port_c_out, 8'h00);
    chk(port_c_oe_n, 8'hAA);
    rd(ADR_DIN_C, 8'hAA);
    wr(ADR_DRV_C, 8'h00);
    $display("test enable and open drain done");
    wr(ADR_CELL_SEL, 8'h0F);
    wr(ADR_PLDDRV_B, 8'hFF);
    wr(ADR_PLDDRV_C, 8'hFF);
    wr(ADR_DIR_B, 8'hFF);
    wr(ADR_DOUT_B, 8'h00);
    w(2);
    chk(port_b_out, 8'hC3);
    chk(port_c_out, 8'h30);
    chk(input_macrocell_b, 8'hC3);
    chk(input_macrocell_c, 8'h30);
    wr(ADR_IMC_B, 8'hFF);
    portb_only_output_cells = 8'h00;
    w(2);
    chk(input_macrocell_b, 8'hC3);
    imc_capture_b = 1'b1;
    w(1);
    imc_capture_b = 1'b0;
    w(1);
    chk(input_macrocell_b, 8'h03);
    $display("test array cells done");
    external_select_terms = 3'h3;
    wr(ADR_PLDDRV_D, 8'h07);
    wr(ADR_MISC, 8'h28);
    w(2);
    chk({5'h00, port_d_out}, 8'h06);
    wr(ADR_DIR_D, 8'h00);
    wr(ADR_OEDEF_D, 8'h07);
    oe_term_d = 3'h2;
    w(2);
    chk({5'h00, port_d_oe_n}, 8'h05);
    $display("test external selects done");
    jtag_tdo = 1'b1;
    wr(ADR_MISC, 8'h07);
    ext_en = 19'h60700;
    ext_val = 19'h60500;
    w(2);
    chk({7'h00, flash_standby}, 8'h01);
    chk({7'h00, pld_clock_input}, 8'h01);
    chk({5'h00, jtag_in}, 8'h05);
    chk({4'h0, port_c_oe_n[3:0]}, 8'h07);
    chk({7'h00, port_c_out[3]}, 8'h01);
    wr(ADR_DOUT_B, 8'h5A);
    rd(ADR_DOUT_B, 8'hAA);
    ext_val = 19'h20500;
    w(2);
    rd(ADR_DOUT_B, 8'h00);
    $display("test dedicated pins done");
    end_of_test();
  end
endmodule : tb
